/* logic/mfls_switch.sv */
`timescale 1ns/1ns
// Contract
// RULE_01 - Trigger rising edge turns output on
// RULE_02 - Long hold enters permanent light
// RULE_03 - Early release starts the off-delay
// RULE_04 - Output clears when elapsed equals off-delay
// RULE_05 - Warning drops output for warning length
// RULE_06 - Further trigger clears timer and output
// RULE_07 - Clear input zeroes time, output off
// RULE_08 - Retentive keeps state over power loss
// RULE_09 - Retention selectable: none or retained
// RULE_10 - All times share one timebase
// RULE_11 - Times selectable from other block values
// RULE_12 - Elapsed time shows current timing
// RULE_13 - Inputs sampled per scan, tick advances
module mfls_switch
    import mfls_pkg::*;
#(
    parameter int CYC_PER_TICK = CYC_10MS
) (
    input  wire logic                      clk,        // Clock, 125 MHz
    input  wire logic                      reset,      // Sync reset, active high
    input  wire logic                      power_up,   // Pulse: power restored
    input  wire logic                      trigger,    // Trigger pin
    input  wire logic                      clear,      // Clear pin
    input  wire logic [NSRC*TIME_W-1:0]    ext_vals,   // Other blocks' actual values
    input  wire logic [3:0]                reg_addr,   // Register address
    input  wire logic [31:0]               reg_wdata,  // Write data
    input  wire logic                      reg_wr,     // Write strobe
    input  wire logic                      reg_rd,     // Read strobe
    output logic      [31:0]               reg_rdata,  // Read data, cycle after
    output logic                           switch_out, // Light output
    output logic      [TIME_W-1:0]         elapsed_time // Current time
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0]        ctrl;
    logic [TIME_W-1:0]  off_delay;
    logic [TIME_W-1:0]  permanent_on_hold_time;
    logic [TIME_W-1:0]  warn_start;
    logic [TIME_W-1:0]  warn_len;
    logic [4*BLK_W-1:0] src_sel;
    mfls_state_e        state;
    logic               trig_s1;
    logic               trig_s2;
    logic               trig_q;
    logic               clr_s1;
    logic               clr_s2;
    logic               tick;
    logic               trig_rise;
    logic               trig_fall;
    logic               warn_on;
    logic [TIME_W-1:0]  t_off;
    logic [TIME_W-1:0]  t_hold;
    logic [TIME_W-1:0]  t_wst;
    logic [TIME_W-1:0]  t_wlen;
    logic [TIME_W-1:0]  warn_from;
    logic [TIME_W-1:0]  warn_to;

    // Picks a time from a register or from another block's value
    function automatic logic [TIME_W-1:0] pick_time(
        input logic                     use_ext,
        input logic [TIME_W-1:0]        own,
        input logic [BLK_W-1:0]         blk,
        input logic [NSRC*TIME_W-1:0]   vals
    );
        logic [TIME_W-1:0] r;
        r = own;
        if (use_ext) begin
            r = (blk < BLK_W'(NSRC)) ? vals[blk[1:0]*TIME_W +: TIME_W] : own;
        end
        return r;
    endfunction : pick_time

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and scan sampling
    always_ff @(posedge clk) begin
        if (reset) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_q  <= 1'b0;
            clr_s1  <= 1'b0;
            clr_s2  <= 1'b0;
        end else begin
            trig_s1 <= trigger;
            trig_s2 <= trig_s1;
            trig_q  <= trig_s2;   // [RULE_13]
            clr_s1  <= clear;
            clr_s2  <= clr_s1;
        end
    end

    assign trig_rise = trig_s2 && !trig_q;
    assign trig_fall = !trig_s2 && trig_q;

    mfls_tick #(
        .CYC_PER_TICK(CYC_PER_TICK)
    ) u_tick (
        .clk    (clk),
        .reset  (reset),
        .tb_sel (ctrl[CTRL_TB_LO +: 2]),   // [RULE_10]
        .tick   (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Effective times
    always_comb begin
        t_off  = pick_time(ctrl[CTRL_EXT_LO],     off_delay,              // [RULE_11]
                           src_sel[0 +: BLK_W], ext_vals);
        t_hold = pick_time(ctrl[CTRL_EXT_LO + 1], permanent_on_hold_time,
                           src_sel[BLK_W +: BLK_W], ext_vals);
        t_wst  = pick_time(ctrl[CTRL_EXT_LO + 2], warn_start,
                           src_sel[2*BLK_W +: BLK_W], ext_vals);
        t_wlen = pick_time(ctrl[CTRL_EXT_LO + 3], warn_len,
                           src_sel[3*BLK_W +: BLK_W], ext_vals);
        warn_from = (t_off > t_wst) ? t_off - t_wst : '0;
        warn_to   = warn_from + t_wlen;
    end

    // Warning window within the off-delay
    assign warn_on = ctrl[CTRL_WARN_EN] && (state == MFLS_DELAY)
                     && (elapsed_time >= warn_from) && (elapsed_time < warn_to); // [RULE_05]

    ////////////////////////////////////////////////////////////////////////
    // Switch sequence
    always_ff @(posedge clk) begin
        if (reset || (power_up && !ctrl[CTRL_RETAIN])) begin   // [RULE_08] [RULE_09]
            state        <= MFLS_OFF;
            elapsed_time <= '0;
        end else if (power_up) begin
            state        <= state;      // Retained block keeps its state
            elapsed_time <= elapsed_time;
        end else if (clr_s2) begin
            state        <= MFLS_OFF;   // [RULE_07]
            elapsed_time <= '0;
        end else begin
            case (state)
                MFLS_OFF: begin
                    if (trig_rise) begin
                        state        <= MFLS_HOLD;   // [RULE_01]
                        elapsed_time <= '0;
                    end
                end
                MFLS_HOLD: begin
                    if (trig_fall) begin
                        state        <= MFLS_DELAY;  // [RULE_03]
                        elapsed_time <= '0;
                    end else if (tick) begin
                        if (elapsed_time + 1'b1 >= t_hold) begin
                            state        <= MFLS_PERM;  // [RULE_02]
                            elapsed_time <= '0;
                        end else begin
                            elapsed_time <= elapsed_time + 1'b1;   // [RULE_12]
                        end
                    end
                end
                MFLS_DELAY: begin
                    if (trig_rise) begin
                        state        <= MFLS_OFF;    // [RULE_06]
                        elapsed_time <= '0;
                    end else if (elapsed_time >= t_off) begin
                        state        <= MFLS_OFF;    // [RULE_04]
                        elapsed_time <= '0;
                    end else if (tick) begin
                        elapsed_time <= elapsed_time + 1'b1;   // [RULE_12]
                    end
                end
                default: begin
                    if (trig_rise) begin
                        state        <= MFLS_OFF;    // [RULE_06]
                        elapsed_time <= '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            switch_out <= 1'b0;
        end else begin
            switch_out <= (state != MFLS_OFF) && !warn_on
                          && !(state == MFLS_DELAY && elapsed_time >= t_off);   // [RULE_04]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl                   <= CTRL_RESET;
            off_delay              <= OFFDLY_RESET;
            permanent_on_hold_time <= HOLD_RESET;
            warn_start             <= WSTART_RESET;
            warn_len               <= WLEN_RESET;
            src_sel                <= '0;
        end else if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                ctrl <= {24'h000000, reg_wdata[7:0]};
            end else if (reg_addr == REG_OFFDLY) begin
                off_delay <= reg_wdata[TIME_W-1:0];
            end else if (reg_addr == REG_HOLD) begin
                permanent_on_hold_time <= reg_wdata[TIME_W-1:0];
            end else if (reg_addr == REG_WSTART) begin
                warn_start <= reg_wdata[TIME_W-1:0];
            end else if (reg_addr == REG_WLEN) begin
                warn_len <= reg_wdata[TIME_W-1:0];
            end else if (reg_addr == REG_SRCSEL) begin
                src_sel <= reg_wdata;
            end
        end
    end

    // Register reads, data valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
                reg_rdata <= ctrl;
            end else if (reg_addr == REG_OFFDLY) begin
                reg_rdata <= {16'h0000, off_delay};
            end else if (reg_addr == REG_HOLD) begin
                reg_rdata <= {16'h0000, permanent_on_hold_time};
            end else if (reg_addr == REG_WSTART) begin
                reg_rdata <= {16'h0000, warn_start};
            end else if (reg_addr == REG_WLEN) begin
                reg_rdata <= {16'h0000, warn_len};
            end else if (reg_addr == REG_SRCSEL) begin
                reg_rdata <= src_sel;
            end else if (reg_addr == REG_STATUS) begin
                reg_rdata <= {28'h0000000, state, warn_on, switch_out};
            end else if (reg_addr == REG_ELAPSED) begin
                reg_rdata <= {16'h0000, elapsed_time};   // [RULE_12]
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule : mfls_switch

/* logic/mfls_pkg.sv */
package mfls_pkg;

    localparam int TIME_W = 16;
    localparam int BLK_W  = 8;
    localparam int NSRC   = 4;

    // Timebase selections: ticks of 10 ms, 1 s or 1 min at 125 MHz, or a tick on every clock cycle
    localparam logic [1:0] TB_10MS  = 2'h0;
    localparam logic [1:0] TB_1S    = 2'h1;
    localparam logic [1:0] TB_1MIN  = 2'h2;
    localparam logic [1:0] TB_CYCLE = 2'h3;

    localparam longint CLK_HZ       = 125000000;
    localparam longint TICK_10MS_NS = 10000000;
    localparam int     CYC_10MS     = int'((TICK_10MS_NS * CLK_HZ) / 64'd1000000000);
    localparam int     TICKS_PER_S  = 100;
    localparam int     TICKS_PER_M  = 6000;

    // Register offsets
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_OFFDLY   = 4'h1;
    localparam logic [3:0] REG_HOLD     = 4'h2;
    localparam logic [3:0] REG_WSTART   = 4'h3;
    localparam logic [3:0] REG_WLEN     = 4'h4;
    localparam logic [3:0] REG_SRCSEL   = 4'h5;
    localparam logic [3:0] REG_STATUS   = 4'h6;
    localparam logic [3:0] REG_ELAPSED  = 4'h7;

    // CTRL field positions
    localparam int CTRL_RETAIN  = 0;
    localparam int CTRL_WARN_EN = 1;
    localparam int CTRL_TB_LO   = 2;
    localparam int CTRL_EXT_LO  = 4;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
    localparam logic [TIME_W-1:0] OFFDLY_RESET = 16'h003C;
    localparam logic [TIME_W-1:0] HOLD_RESET   = 16'h000A;
    localparam logic [TIME_W-1:0] WSTART_RESET = 16'h001E;
    localparam logic [TIME_W-1:0] WLEN_RESET   = 16'h0014;

    typedef enum logic [1:0] {
        MFLS_OFF     = 2'b00,
        MFLS_HOLD    = 2'b01,
        MFLS_DELAY   = 2'b11,
        MFLS_PERM    = 2'b10
    } mfls_state_e;

endpackage : mfls_pkg

/* logic/mfls_tick.sv */
`timescale 1ns/1ns
module mfls_tick
    import mfls_pkg::*;
#(
    parameter int CYC_PER_TICK = CYC_10MS
) (
    input  wire logic       clk,     // Clock
    input  wire logic       reset,   // Sync reset
    input  wire logic [1:0] tb_sel,  // Timebase
    output logic            tick     // One-cycle tick
);
    logic [31:0] base_cnt;
    logic [15:0] sub_cnt;
    logic        base_tick;
    logic [15:0] sub_max;

    always_comb begin
        case (tb_sel)
            TB_1S:   sub_max = 16'(TICKS_PER_S - 1);
            TB_1MIN: sub_max = 16'(TICKS_PER_M - 1);
            default: sub_max = 16'h0000;
        endcase
    end

    assign base_tick = (base_cnt == 32'(CYC_PER_TICK - 1));

    always_ff @(posedge clk) begin
        if (reset || base_tick) begin
            base_cnt <= 32'h0000_0000;
        end else begin
            base_cnt <= base_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sub_cnt <= 16'h0000;
        end else if (base_tick) begin
            sub_cnt <= (sub_cnt >= sub_max) ? 16'h0000 : sub_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tick <= 1'b0;
        end else if (tb_sel == TB_CYCLE) begin
            tick <= 1'b1;
        end else begin
            tick <= base_tick && (sub_cnt >= sub_max);
        end
    end
endmodule : mfls_tick

/* bench/mfls_monitor.sv */
`timescale 1ns/1ns
module mfls_monitor
    import mfls_pkg::*;
#(
    parameter int CYC_PER_TICK = CYC_10MS
) (
    input wire logic              clk,         // Clock
    input wire logic              reset,       // Reset
    input wire logic              power_up,    // Power back
    input wire logic              trigger,     // Trigger
    input wire logic              clear,       // Clear
    input wire logic [3:0]        reg_addr,    // Address
    input wire logic              reg_rd,      // Read
    input wire logic [31:0]       reg_rdata,   // Read data
    input wire logic              switch_out,  // Output
    input wire logic [TIME_W-1:0] elapsed_time // Time
);
    logic [3:0] ago_trg, ago_clr, ago_pwr, ago_run;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    function automatic logic [3:0] age(input logic hit, input logic [3:0] a);
        return hit ? 4'h0 : a + {3'h0, a != 4'hF};
    endfunction : age

    // Cycles since each possible cause of an output change
    always_ff @(posedge clk) begin
        ago_trg <= reset ? 4'hF : age(trigger, ago_trg);
        ago_clr <= reset ? 4'hF : age(clear, ago_clr);
        ago_pwr <= reset ? 4'hF : age(power_up, ago_pwr);
        ago_run <= reset ? 4'hF : age(elapsed_time != '0, ago_run);
    end

    AST_RESET_OUT:
        assert property (disable iff (1'b0) reset |=> !switch_out && elapsed_time == '0)
        else $error("reset left output or time set");
    AST_RDATA_IDLE:
        assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    AST_UNMAPPED_RD:
        assert property (reg_rd && reg_addr > REG_ELAPSED |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_CLEAR_ZERO:
        assert property (clear [*4] |-> ##2 (!switch_out && elapsed_time == '0))
        else $error("clear did not zero the block");
    AST_TRIG_ON:
        assert property (($rose(trigger) && !switch_out && elapsed_time == '0 && !clear)
            ##1 (trigger && !clear && !power_up) [*5] |=> switch_out)
        else $error("trigger did not turn output on");
    AST_RISE_CAUSE:
        assert property ($rose(switch_out) |-> ago_trg <= 4'h8 || ago_run <= 4'h3)
        else $error("output rose without cause");
    AST_FALL_CAUSE:
        assert property ($fell(switch_out) |-> ago_trg <= 4'h8 || ago_clr <= 4'h8
            || ago_pwr <= 4'h8 || ago_run <= 4'h3)
        else $error("output fell without cause");
    AST_ELAPSED_STEP:
        assert property (!$stable(elapsed_time) |-> elapsed_time == '0
            || elapsed_time == $past(elapsed_time) + 16'h1)
        else $error("elapsed time jumped");
endmodule : mfls_monitor

////////////////////////////////////////
bind mfls_switch mfls_monitor #(.CYC_PER_TICK(CYC_PER_TICK)) u_monitor (
    .clk(clk), .reset(reset), .power_up(power_up), .trigger(trigger),
    .clear(clear), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .switch_out(switch_out), .elapsed_time(elapsed_time)
);

/* bench/mfls_prog.sv */
`timescale 1ns/1ns
module mfls_prog (
    input  wire logic clk,     // Clock
    output logic      trigger, // Trigger pin
    output logic      clear    // Clear pin
);
    initial begin
        trigger = 1'b0;
        clear   = 1'b0;
    end

    // Levels held whole cycles; the block synchronises them
    task automatic press(input int n);
        @(posedge clk);
        trigger <= 1'b1;
        repeat (n) @(posedge clk);
        trigger <= 1'b0;
    endtask : press

    task automatic zap(input int n);
        @(posedge clk);
        clear <= 1'b1;
        repeat (n) @(posedge clk);
        clear <= 1'b0;
    endtask : zap
endmodule : mfls_prog

/* bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    import mfls_pkg::*;
    localparam logic [31:0] DFLT [5] = '{32'h4, 32'h3C, 32'hA, 32'h1E, 32'h14};
    localparam int          CPT      = 4;
    logic                   clk, reset, power_up, trigger, clear, reg_wr, reg_rd, switch_out;
    logic [NSRC*TIME_W-1:0] ext_vals;
    logic [3:0]             reg_addr;
    logic [31:0]            reg_wdata, reg_rdata;
    logic [TIME_W-1:0]      elapsed_time, e;
    int                     errors, checks, n;

    mfls_switch #(.CYC_PER_TICK(CPT)) dut (
        .clk(clk), .reset(reset), .power_up(power_up), .trigger(trigger), .clear(clear),
        .ext_vals(ext_vals), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .switch_out(switch_out),
        .elapsed_time(elapsed_time)
    );
    mfls_prog prog (.clk(clk), .trigger(trigger), .clear(clear));

    always #4 clk = ~clk;

    task report_and_stop;
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk

    task tick;
        @(posedge clk) #1;
    endtask : tick

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, input logic [31:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, x);
    endtask : rd

    // Bounded wait for the output (sel 0) or the elapsed time (sel 1)
    task wt(input bit sel, input int v, input int lim);
        n = 0;
        #1;
        while (sel ? (elapsed_time !== TIME_W'(v)) : (switch_out !== v[0])) begin
            tick;
            n++;
            if (n > lim) begin
                errors++;
                report_and_stop;
            end
        end
    endtask : wt

    ////////////////////////////////////////
    task go(input int k);
        prog.press(3);
        wt(0, 1, 8);
        repeat (k) tick;
    endtask : go

    task s_short(input int t);
        go(6);
        e = elapsed_time;
        repeat (5) tick;
        chk("elapsed_step", elapsed_time, e + 16'h5);
        rd(REG_ELAPSED, 32'(e + 16'h6));
        wt(0, 0, t + 20);
        chk("delay_len", n + 13 >= t && n + 13 <= t + 8, 1'b1);
    endtask : s_short

    // Elapsed time advances once per timebase tick in the 10 ms, 1 s and 1 min modes
    task s_base(input logic [1:0] tb, input int per);
        wr(REG_CTRL, {28'h0000000, tb, 2'b00});
        go(4);
        e = elapsed_time;
        repeat (2 * per) tick;
        chk("tick_rate", elapsed_time, e + 16'h2);
        prog.press(2);
        wt(0, 0, 10);
    endtask : s_base

    task s_perm;
        prog.press(16);
        repeat (40) tick;
        chk("perm_on", switch_out, 1'b1);
        rd(REG_STATUS, {28'h0000000, MFLS_PERM, 2'b01});
        prog.press(2);
        wt(0, 0, 10);
        go(4);
        prog.press(2);
        wt(0, 0, 10);
    endtask : s_perm

    task s_power(input logic keep);
        wr(REG_CTRL, 32'hC | 32'(keep));
        go(8);
        e = elapsed_time;
        @(posedge clk);
        power_up <= 1'b1;
        @(posedge clk);
        power_up <= 1'b0;
        repeat (2) tick;
        chk("power_out", switch_out, keep);
        chk("power_time", elapsed_time > e, keep);
        wt(0, 0, 40);
    endtask : s_power

    initial begin
        clk       = 1'b0;
        reset     = 1'b1;
        power_up  = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
        ext_vals  = 64'h0030_0019_0007_0011;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(4'(i), DFLT[i]);
        end
        rd(4'h8, 32'h0);
        wr(REG_CTRL, 32'hC);
        wr(REG_OFFDLY, 32'h14);
        rd(REG_OFFDLY, 32'h14);
        go(5);
        prog.zap(4);
        wt(0, 0, 6);
        chk("clear_time", elapsed_time, 32'h0);
        s_perm;
        s_short(20);
        wr(REG_SRCSEL, 32'h302);
        rd(REG_SRCSEL, 32'h302);
        wr(REG_CTRL, 32'h3C);
        s_short(25);
        @(posedge clk);
        ext_vals[63:48] <= 16'h0004;
        prog.press(8);
        repeat (40) tick;
        chk("ext_hold", switch_out, 1'b1);
        prog.press(2);
        wt(0, 0, 10);
        wr(REG_CTRL, 32'hE);
        wr(REG_WSTART, 32'h8);
        wr(REG_WLEN, 32'h4);
        go(0);
        wt(1, 14, 30);
        chk("warn_gap", switch_out, 1'b0);
        rd(REG_STATUS, {28'h0000000, MFLS_DELAY, 2'b10});
        wt(1, 18, 10);
        chk("warn_end", switch_out, 1'b1);
        wt(0, 0, 10);
        s_base(TB_10MS, CPT);
        s_base(TB_1S, CPT * TICKS_PER_S);
        s_base(TB_1MIN, CPT * TICKS_PER_M);
        s_power(1'b0);
        s_power(1'b1);
        report_and_stop;
    end
endmodule : tb_top
